//--- rtl/ppl_edge_detect.sv
// Two-flop synchroniser with rise and fall detection for one probe source
`timescale 1ns/1ps
module ppl_edge_detect (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic level_in,
	output logic rise_out,
	output logic fall_out
);

	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else if (ce) begin
			meta_reg <= level_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// Compare consecutive synchronised samples
	assign rise_out = sync_reg & ~prev_reg;
	assign fall_out = ~sync_reg & prev_reg;

endmodule : ppl_edge_detect

//--- rtl/ppl_pkg.sv
// Constants, register map and types for the position probe latch
package ppl_pkg;

	// Bus geometry
	localparam int ADR_W = 20;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;
	localparam int IDX_W = 18;
	localparam int CFG_W = 16;
	localparam int POS_W = 32;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_PROBE_CONFIG = 18'h060b8;
	localparam logic [IDX_W-1:0] IDX_PROBE_STATUS = 18'h060b9;
	localparam logic [IDX_W-1:0] IDX_PROBE_ONE_RISE_POSITION = 18'h060ba;
	localparam logic [IDX_W-1:0] IDX_PROBE_ONE_FALL_POSITION = 18'h060bb;
	localparam logic [IDX_W-1:0] IDX_PROBE_TWO_RISE_POSITION = 18'h060bc;
	localparam logic [IDX_W-1:0] IDX_PROBE_TWO_FALL_POSITION = 18'h060bd;

	// Reset values
	localparam logic [CFG_W-1:0] PROBE_CONFIG_RESET = 16'h0000;
	localparam logic [POS_W-1:0] POSITION_RESET = 32'h00000000;

	// Channel geometry
	localparam int CHANNELS = 2;
	localparam int EDGES = 2;
	localparam int ENTRIES = 4;

	// Per-channel fields in config and status; channel n sits n strides up
	localparam int CH_STRIDE = 8;
	localparam int CFG_EN_BIT = 0;
	localparam int CFG_CONT_BIT = 1;
	localparam int CFG_SRC_BIT = 2;
	localparam int STS_RISE_BIT = 0;
	localparam int STS_FALL_BIT = 1;

	// Entry order within the position store
	localparam int EDGE_RISE = 0;
	localparam int EDGE_FALL = 1;

	// Bus slave states
	typedef enum logic {
		BUS_IDLE,
		BUS_ACK
	} ppl_bus_state_type;

endpackage : ppl_pkg

//--- rtl/ppl_position_probe_latch.sv
// Two-channel position probe latch with a classic Wishbone register slave
`timescale 1ns/1ps
module ppl_position_probe_latch (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic [ppl_pkg::ADR_W-1:0] ADR_I,
	input wire logic [ppl_pkg::DAT_W-1:0] DAT_I,
	output logic [ppl_pkg::DAT_W-1:0] DAT_O,
	input wire logic WE_I,
	input wire logic [ppl_pkg::SEL_W-1:0] SEL_I,
	input wire logic STB_I,
	input wire logic CYC_I,
	output logic ACK_O,
	input wire logic PROBE_ONE_EXTERNAL_INPUT,
	input wire logic PROBE_TWO_EXTERNAL_INPUT,
	input wire logic INDEX_PULSE,
	input wire logic [ppl_pkg::POS_W-1:0] ENCODER_POSITION
);

	ppl_pkg::ppl_bus_state_type bus_state_reg;
	ppl_pkg::ppl_bus_state_type bus_state_next;
	logic [ppl_pkg::CFG_W-1:0] config_reg;
	logic [ppl_pkg::CFG_W-1:0] config_next;
	logic [ppl_pkg::ENTRIES-1:0] captured_reg;
	logic [ppl_pkg::ENTRIES-1:0] captured_next;
	logic [ppl_pkg::CHANNELS-1:0] enable_prev_reg;
	logic [ppl_pkg::POS_W-1:0] position_reg [ppl_pkg::ENTRIES];
	logic [ppl_pkg::DAT_W-1:0] dat_reg;
	logic [ppl_pkg::DAT_W-1:0] dat_next;

	logic [ppl_pkg::CHANNELS-1:0] enable;
	logic [ppl_pkg::CHANNELS-1:0] continuous;
	logic [ppl_pkg::CHANNELS-1:0] source_index;
	logic [ppl_pkg::CHANNELS-1:0] source_level;
	logic [ppl_pkg::CHANNELS-1:0] rise_det;
	logic [ppl_pkg::CHANNELS-1:0] fall_det;
	logic [ppl_pkg::CHANNELS-1:0] arm;
	logic [ppl_pkg::ENTRIES-1:0] capture;
	logic [ppl_pkg::ENTRIES-1:0] rearm;
	logic bus_req;
	logic bus_write;
	logic [ppl_pkg::IDX_W-1:0] word_idx;
	logic [ppl_pkg::DAT_W-1:0] status_word;

	// Source selection per channel
	assign source_level[0] = source_index[0] ? INDEX_PULSE : PROBE_ONE_EXTERNAL_INPUT;
	assign source_level[1] = source_index[1] ? INDEX_PULSE : PROBE_TWO_EXTERNAL_INPUT;

	genvar ch;
	genvar ed;
	generate
		for (ch = 0; ch < ppl_pkg::CHANNELS; ch++) begin : g_channel
			assign enable[ch] = config_reg[ch*ppl_pkg::CH_STRIDE+ppl_pkg::CFG_EN_BIT];
			assign continuous[ch] = config_reg[ch*ppl_pkg::CH_STRIDE+ppl_pkg::CFG_CONT_BIT];
			assign source_index[ch] = config_reg[ch*ppl_pkg::CH_STRIDE+ppl_pkg::CFG_SRC_BIT];
			// Enable seen going high opens a new single-capture window
			assign arm[ch] = enable[ch] & ~enable_prev_reg[ch];

			ppl_edge_detect u_edge (
				.clk(CORE_CLK),
				.rst_n(RST_N),
				.ce(CE),
				.level_in(source_level[ch]),
				.rise_out(rise_det[ch]),
				.fall_out(fall_det[ch])
			);

			for (ed = 0; ed < ppl_pkg::EDGES; ed++) begin : g_edge
				localparam int ENT = ch * ppl_pkg::EDGES + ed;
				logic det;
				assign det = (ed == ppl_pkg::EDGE_RISE) ? rise_det[ch] : fall_det[ch];
				assign rearm[ENT] = arm[ch];
				// Gate on enable; single mode blocks after first capture
				assign capture[ENT] = enable[ch] & det
					& (continuous[ch] | ~captured_reg[ENT] | arm[ch]);

				always_ff @(posedge CORE_CLK or negedge RST_N) begin
					if (!RST_N) begin
						position_reg[ENT] <= ppl_pkg::POSITION_RESET;
					end else if (CE && capture[ENT]) begin
						position_reg[ENT] <= ENCODER_POSITION;
					end
				end
			end
		end
	endgenerate

	// Capture flags: a capture in the re-arm cycle wins
	assign captured_next = capture | (captured_reg & ~rearm);

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			captured_reg <= '0;
			enable_prev_reg <= '0;
		end else if (CE) begin
			captured_reg <= captured_next;
			enable_prev_reg <= enable;
		end
	end

	// Wishbone slave: one wait state, ack for exactly one cycle
	assign bus_req = CYC_I & STB_I;
	assign bus_write = bus_req & WE_I & (bus_state_reg == ppl_pkg::BUS_ACK);
	assign word_idx = ADR_I[ppl_pkg::ADR_W-1:2];

	always_comb begin
		case (bus_state_reg)
			ppl_pkg::BUS_IDLE: begin
				bus_state_next = bus_req ? ppl_pkg::BUS_ACK : ppl_pkg::BUS_IDLE;
			end
			ppl_pkg::BUS_ACK: begin
				bus_state_next = ppl_pkg::BUS_IDLE;
			end
			default: begin
				bus_state_next = ppl_pkg::BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			bus_state_reg <= ppl_pkg::BUS_IDLE;
		end else if (CE) begin
			bus_state_reg <= bus_state_next;
		end
	end

	assign ACK_O = (bus_state_reg == ppl_pkg::BUS_ACK);

	// Config write with byte lanes
	always_comb begin
		config_next = config_reg;
		if (bus_write && word_idx == ppl_pkg::IDX_PROBE_CONFIG) begin
			if (SEL_I[0]) begin
				config_next[7:0] = DAT_I[7:0];
			end
			if (SEL_I[1]) begin
				config_next[15:8] = DAT_I[15:8];
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			config_reg <= ppl_pkg::PROBE_CONFIG_RESET;
		end else if (CE) begin
			config_reg <= config_next;
		end
	end

	// Status word: capture flags per channel
	always_comb begin
		status_word = '0;
		for (int c = 0; c < ppl_pkg::CHANNELS; c++) begin
			status_word[c*ppl_pkg::CH_STRIDE+ppl_pkg::STS_RISE_BIT] =
				captured_reg[c*ppl_pkg::EDGES+ppl_pkg::EDGE_RISE];
			status_word[c*ppl_pkg::CH_STRIDE+ppl_pkg::STS_FALL_BIT] =
				captured_reg[c*ppl_pkg::EDGES+ppl_pkg::EDGE_FALL];
		end
	end

	// Read mux; unmapped words read zero
	always_comb begin
		case (word_idx)
			ppl_pkg::IDX_PROBE_CONFIG: begin
				dat_next = {16'h0000, config_reg};
			end
			ppl_pkg::IDX_PROBE_STATUS: begin
				dat_next = status_word;
			end
			ppl_pkg::IDX_PROBE_ONE_RISE_POSITION: begin
				dat_next = position_reg[0];
			end
			ppl_pkg::IDX_PROBE_ONE_FALL_POSITION: begin
				dat_next = position_reg[1];
			end
			ppl_pkg::IDX_PROBE_TWO_RISE_POSITION: begin
				dat_next = position_reg[2];
			end
			ppl_pkg::IDX_PROBE_TWO_FALL_POSITION: begin
				dat_next = position_reg[3];
			end
			default: begin
				dat_next = '0;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			dat_reg <= '0;
		end else if (CE && bus_req && bus_state_reg == ppl_pkg::BUS_IDLE) begin
			dat_reg <= dat_next;
		end
	end

	assign DAT_O = dat_reg;

	// Checks
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_one_quiet;
		(CE && !source_index[0] && !PROBE_ONE_EXTERNAL_INPUT) [*3];
	endsequence

	sequence s_one_step;
		(CE && !source_index[0] && PROBE_ONE_EXTERNAL_INPUT) ##1 (CE && !source_index[0]);
	endsequence

	sequence s_one_rise_hit;
		CE && enable[0] && rise_det[0] && (continuous[0] || !captured_reg[0] || arm[0]);
	endsequence

	a_edge_detect_lag: assert property (
		s_one_quiet ##1 s_one_step |=> rise_det[0])
		else $error("Probe one rise not detected two edges after input rose");

	a_one_rise_pos: assert property (
		s_one_rise_hit |=> position_reg[0] == $past(ENCODER_POSITION))
		else $error("Probe one rise position not captured");

	a_one_fall_pos: assert property (
		CE && enable[0] && fall_det[0] && (continuous[0] || !captured_reg[1] || arm[0])
		|=> position_reg[1] == $past(ENCODER_POSITION))
		else $error("Probe one fall position not captured");

	a_two_rise_pos: assert property (
		CE && enable[1] && rise_det[1] && (continuous[1] || !captured_reg[2] || arm[1])
		|=> position_reg[2] == $past(ENCODER_POSITION))
		else $error("Probe two rise position not captured");

	a_two_fall_pos: assert property (
		CE && enable[1] && fall_det[1] && (continuous[1] || !captured_reg[3] || arm[1])
		|=> position_reg[3] == $past(ENCODER_POSITION))
		else $error("Probe two fall position not captured");

	a_single_hold: assert property (
		CE && enable[0] && !continuous[0] && captured_reg[0] && !arm[0]
		|=> $stable(position_reg[0]) && captured_reg[0])
		else $error("Single mode probe one rise recaptured");

	a_disabled_hold: assert property (
		!enable[1] |=> $stable(position_reg[2]) && $stable(position_reg[3]))
		else $error("Disabled probe two changed its positions");

	a_cont_overwrite: assert property (
		CE && enable[0] && continuous[0] && captured_reg[0] && rise_det[0]
		|=> position_reg[0] == $past(ENCODER_POSITION))
		else $error("Continuous mode missed a second capture");

	a_config_write: assert property (
		CE && bus_write && word_idx == ppl_pkg::IDX_PROBE_CONFIG && SEL_I[1:0] == 2'h3
		|=> config_reg == $past(DAT_I[15:0]) && !ACK_O)
		else $error("Config write not stored or ack held");

	a_ack_one_cycle: assert property (
		CE && ACK_O |=> !ACK_O)
		else $error("Acknowledge held longer than one cycle");

	a_ack_follows_req: assert property (
		CE && bus_req && !ACK_O |=> ACK_O)
		else $error("Bus request not acknowledged in the next cycle");

	a_no_stray_ack: assert property (
		CE && !bus_req && !ACK_O |=> !ACK_O)
		else $error("Acknowledge without a request");

	a_read_config: assert property (
		CE && bus_req && !ACK_O && word_idx == ppl_pkg::IDX_PROBE_CONFIG
		|=> DAT_O == {16'h0000, $past(config_reg)})
		else $error("Config read data wrong");

	a_read_status: assert property (
		CE && bus_req && !ACK_O && word_idx == ppl_pkg::IDX_PROBE_STATUS
		|=> DAT_O[ppl_pkg::STS_RISE_BIT] == $past(captured_reg[0])
		&& DAT_O[ppl_pkg::CH_STRIDE+ppl_pkg::STS_RISE_BIT] == $past(captured_reg[2]))
		else $error("Status read data wrong");

	a_read_hold: assert property (
		!(CE && bus_req && !ACK_O) |=> $stable(DAT_O))
		else $error("Read data changed without a new request");

	a_sel_low_lane: assert property (
		CE && bus_write && word_idx == ppl_pkg::IDX_PROBE_CONFIG && SEL_I[1:0] == 2'h1
		|=> config_reg[15:8] == $past(config_reg[15:8])
		&& config_reg[7:0] == $past(DAT_I[7:0]))
		else $error("Config byte lane write wrong");

	a_one_disabled_hold: assert property (
		!enable[0] |=> $stable(position_reg[0]) && $stable(position_reg[1]))
		else $error("Disabled probe one changed its positions");

	a_one_fall_single: assert property (
		CE && enable[0] && !continuous[0] && captured_reg[1] && !arm[0]
		|=> $stable(position_reg[1]) && captured_reg[1])
		else $error("Single mode probe one fall recaptured");

	a_arm_clear: assert property (
		CE && arm[0] && !rise_det[0] |=> !captured_reg[0])
		else $error("Re-enable did not clear probe one rise flag");

	a_both_capture: assert property (
		CE && enable[0] && enable[1] && continuous[0] && continuous[1]
		&& rise_det[0] && rise_det[1]
		|=> position_reg[0] == $past(ENCODER_POSITION)
		&& position_reg[2] == $past(ENCODER_POSITION))
		else $error("Probes did not capture concurrently");

	sequence s_index_one_quiet;
		(CE && source_index[0] && !INDEX_PULSE) [*3];
	endsequence

	sequence s_index_one_step;
		(CE && source_index[0] && INDEX_PULSE) ##1 (CE && source_index[0]);
	endsequence

	a_index_one_lag: assert property (
		s_index_one_quiet ##1 s_index_one_step |=> rise_det[0])
		else $error("Probe one did not follow the index pulse");

	sequence s_index_two_quiet;
		(CE && source_index[1] && !INDEX_PULSE) [*3];
	endsequence

	sequence s_index_two_step;
		(CE && source_index[1] && INDEX_PULSE) ##1 (CE && source_index[1]);
	endsequence

	a_index_two_lag: assert property (
		s_index_two_quiet ##1 s_index_two_step |=> rise_det[1])
		else $error("Probe two did not follow the index pulse");

endmodule : ppl_position_probe_latch

//--- testbench/ppl_position_probe_latch_tb.sv
// Self-checking bench for the position probe latch
`timescale 1ns/1ps
module ppl_position_probe_latch_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [19:0] adr = 20'h00000;
	logic [31:0] dat_i = 32'h00000000;
	logic [31:0] enc = 32'h00000000;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat_o;
	logic ack;
	logic ce = 1'b1;
	logic e1;
	logic e2;
	logic ix;
	int error_cnt = 0;
	int checked = 0;
	int cycles = 0;
	always #12.5 clk = ~clk;
	ppl_probe_source_model src (.clk(clk), .ext_one(e1), .ext_two(e2), .index(ix));
	ppl_position_probe_latch dut (.CORE_CLK(clk), .RST_N(rst_n), .CE(ce),
		.ADR_I(adr), .DAT_I(dat_i), .DAT_O(dat_o), .WE_I(we), .SEL_I(sel),
		.STB_I(stb), .CYC_I(cyc), .ACK_O(ack), .PROBE_ONE_EXTERNAL_INPUT(e1),
		.PROBE_TWO_EXTERNAL_INPUT(e2), .INDEX_PULSE(ix), .ENCODER_POSITION(enc));
	task conclude;
		if (error_cnt == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task bus(input logic w, input logic [17:0] i, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		@(posedge clk);
		{cyc, stb, we, adr, dat_i, sel} <= {2'b11, w, i, 2'b00, d, s};
		do @(posedge clk); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task wr(input logic [17:0] i, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		bus(1'b1, i, d, s, q);
	endtask : wr
	task rd(input logic [17:0] i, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, i, 32'h00000000, 4'hf, q);
		chk($sformatf("word %h", i), q, exp);
	endtask : rd
	// Encoder value changes first, probe levels one clock edge later, then settle
	task lv(input logic [2:0] v, input logic [31:0] p);
		enc <= p;
		src.set(v);
		repeat (5) @(posedge clk);
	endtask : lv
	task t_regs;
		rd(ppl_pkg::IDX_PROBE_CONFIG, 32'h00000000);
		wr(ppl_pkg::IDX_PROBE_CONFIG, 32'hffff0707, 4'h1);
		rd(ppl_pkg::IDX_PROBE_CONFIG, 32'h00000007);
		rd(18'h00000, 32'h00000000);
		wr(ppl_pkg::IDX_PROBE_CONFIG, 32'h00000000, 4'hf);
	endtask : t_regs
	task t_cont;
		wr(ppl_pkg::IDX_PROBE_CONFIG, 32'h00000303, 4'hf);
		lv(3'b001, 32'h000000a1);
		rd(ppl_pkg::IDX_PROBE_ONE_RISE_POSITION, 32'h000000a1);
		lv(3'b000, 32'h000000b2);
		lv(3'b011, 32'hfffffff3);
		lv(3'b000, 32'h800000c4);
		rd(ppl_pkg::IDX_PROBE_ONE_RISE_POSITION, 32'hfffffff3);
		rd(ppl_pkg::IDX_PROBE_ONE_FALL_POSITION, 32'h800000c4);
		rd(ppl_pkg::IDX_PROBE_TWO_RISE_POSITION, 32'hfffffff3);
		rd(ppl_pkg::IDX_PROBE_TWO_FALL_POSITION, 32'h800000c4);
	endtask : t_cont
	task t_single;
		// Drop enable first so single mode opens a fresh window
		wr(ppl_pkg::IDX_PROBE_CONFIG, 32'h00000000, 4'hf);
		wr(ppl_pkg::IDX_PROBE_CONFIG, 32'h00000001, 4'hf);
		lv(3'b011, 32'h00000011);
		lv(3'b000, 32'h00000012);
		lv(3'b001, 32'h00000013);
		lv(3'b000, 32'h00000014);
		rd(ppl_pkg::IDX_PROBE_ONE_RISE_POSITION, 32'h00000011);
		rd(ppl_pkg::IDX_PROBE_ONE_FALL_POSITION, 32'h00000012);
		rd(ppl_pkg::IDX_PROBE_TWO_RISE_POSITION, 32'hfffffff3);
		rd(ppl_pkg::IDX_PROBE_STATUS, 32'h00000303);
		wr(ppl_pkg::IDX_PROBE_CONFIG, 32'h00000000, 4'hf);
		lv(3'b001, 32'h00000015);
		rd(ppl_pkg::IDX_PROBE_ONE_RISE_POSITION, 32'h00000011);
		wr(ppl_pkg::IDX_PROBE_CONFIG, 32'h00000001, 4'hf);
		rd(ppl_pkg::IDX_PROBE_STATUS, 32'h00000300);
		lv(3'b000, 32'h00000016);
		lv(3'b001, 32'h00000017);
		rd(ppl_pkg::IDX_PROBE_ONE_RISE_POSITION, 32'h00000017);
		lv(3'b000, 32'h00000018);
	endtask : t_single
	task t_index;
		wr(ppl_pkg::IDX_PROBE_CONFIG, 32'h00000707, 4'hf);
		lv(3'b100, 32'h00000021);
		lv(3'b000, 32'h00000022);
		lv(3'b011, 32'h00000023);
		rd(ppl_pkg::IDX_PROBE_ONE_RISE_POSITION, 32'h00000021);
		rd(ppl_pkg::IDX_PROBE_TWO_RISE_POSITION, 32'h00000021);
		rd(ppl_pkg::IDX_PROBE_TWO_FALL_POSITION, 32'h00000022);
		wr(ppl_pkg::IDX_PROBE_ONE_RISE_POSITION, 32'h5a5a5a5a, 4'hf);
		rd(ppl_pkg::IDX_PROBE_ONE_RISE_POSITION, 32'h00000021);
		rd(ppl_pkg::IDX_PROBE_CONFIG, 32'h00000707);
	endtask : t_index
	// Clock enable low freezes the synchroniser; capture follows its return
	task t_freeze;
		ce <= 1'b0;
		lv(3'b100, 32'h00000031);
		ce <= 1'b1;
		enc <= 32'h00000032;
		repeat (5) @(posedge clk);
		rd(ppl_pkg::IDX_PROBE_ONE_RISE_POSITION, 32'h00000032);
		rd(ppl_pkg::IDX_PROBE_TWO_RISE_POSITION, 32'h00000032);
	endtask : t_freeze
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_cont();
		t_single();
		t_index();
		t_freeze();
		conclude();
	end
endmodule : ppl_position_probe_latch_tb

//--- testbench/ppl_probe_source_model.sv
// Far-side model: probe one and two external inputs and encoder index
`timescale 1ns/1ps
module ppl_probe_source_model (
	input wire logic clk,
	output logic ext_one,
	output logic ext_two,
	output logic index
);
	initial begin
		ext_one = 1'b0;
		ext_two = 1'b0;
		index = 1'b0;
	end
	// Levels change after an edge and stand for several cycles
	task set(input logic [2:0] v);
		@(posedge clk);
		{index, ext_two, ext_one} <= v;
	endtask : set
endmodule : ppl_probe_source_model
